// file: design/cec_top.sv
`timescale 1ns/1ps
//
// Contract
// - forced key expansion runs with next cipher start
// - hardware clears force bit after expansion
// - last input: finish, raise idle flag
// - more input: halt, raise waiting flag
// - digest length field is bytes minus one
// - type bit: 0 cipher, 1 hash
// - interrupt only when enable bit set
// - key size 00=128, 01=192, else 256
// - cipher writeback all or final block
// - chaining 0x ECB, 10 CTR, 11 CBC
// - hash family by mode, digest by algorithm
// - start bit begins run, self-clearing
//
module cec_top
  import cec_pkg::*;
(
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  // register port
  input  wire logic [31:0] i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [31:0] o_reg_rdata,
  // engine datapath handshake
  input  wire logic        i_eng_input_done,
  input  wire logic        i_eng_kexp_done,
  output logic             o_eng_start,
  output logic             o_eng_kexp,
  output cec_cfg_t         o_eng_cfg,
  // engine state
  output logic             o_engine_idle_flag,
  output logic             o_wait_for_input,
  // interrupt
  output logic             o_irq
);

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  wire hit_ctrl     = (i_reg_addr == CEC_ADDR_CTRL);
  wire hit_start    = (i_reg_addr == CEC_ADDR_START);
  wire hit_status   = (i_reg_addr == CEC_ADDR_STATUS);
  wire hit_irq_stat = (i_reg_addr == CEC_ADDR_IRQ_STAT);
  wire hit_irq_mask = (i_reg_addr == CEC_ADDR_IRQ_MASK);

  wire wr_ctrl      = i_reg_wr && hit_ctrl;
  wire wr_start     = i_reg_wr && hit_start && i_reg_wdata[CEC_START_BIT];
  wire wr_irq_stat  = i_reg_wr && hit_irq_stat;
  wire wr_irq_mask  = i_reg_wr && hit_irq_mask;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cec_ctrl_t               ctrl_r;
  cec_ctrl_t               ctrl_nxt;
  cec_state_t              state_r;
  cec_state_t              state_nxt;
  logic [CEC_IRQ_W-1:0]    irq_stat_r;
  logic [CEC_IRQ_W-1:0]    irq_stat_nxt;
  logic [CEC_IRQ_W-1:0]    irq_mask_r;
  logic [CEC_IRQ_W-1:0]    irq_mask_nxt;
  logic [31:0]             rdata_r;
  logic [31:0]             rdata_nxt;
  logic                    start_r;
  logic                    kexp_r;
  logic                    kexp_busy_r;
  logic                    kexp_busy_nxt;
  cec_cfg_t                cfg_dec;
  cec_cfg_t                cfg_r;

  // ---------------------------------------------------------------
  // configuration decode
  // ---------------------------------------------------------------
  cec_cfg_decode u_decode (
    .i_ctrl (ctrl_r),
    .o_cfg  (cfg_dec)
  );

  // ---------------------------------------------------------------
  // run sequencing
  // ---------------------------------------------------------------
  wire is_idle    = (state_r == CEC_S_IDLE);
  wire is_run     = (state_r == CEC_S_RUN);
  wire is_wait    = (state_r == CEC_S_WAIT);
  // a start while running is ignored
  wire start_ok   = wr_start && !is_run;
  wire run_end    = is_run && i_eng_input_done;
  wire end_final  = run_end && !ctrl_r.more_input;
  wire end_halt   = run_end && ctrl_r.more_input;
  // expansion only for a cipher run with the force bit set
  wire kexp_go    = start_ok && ctrl_r.force_key_expansion &&
                    !ctrl_r.hash_select;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CEC_S_IDLE: begin
        if (start_ok) begin
          state_nxt = CEC_S_RUN;
        end
      end
      CEC_S_RUN: begin
        if (end_final) begin
          state_nxt = CEC_S_IDLE;
        end else if (end_halt) begin
          state_nxt = CEC_S_WAIT;
        end
      end
      CEC_S_WAIT: begin
        if (start_ok) begin
          state_nxt = CEC_S_RUN;
        end
      end
      default: begin
        state_nxt = CEC_S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  wire cec_ctrl_t wr_word    = cec_ctrl_t'(i_reg_wdata & CEC_CTRL_WMASK);
  wire            kexp_clear = kexp_busy_r && i_eng_kexp_done;
  wire            kexp_set   = wr_ctrl && wr_word.force_key_expansion;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = wr_word;
    end
    // a software set in the same cycle wins over the clear
    if (kexp_clear && !kexp_set) begin
      ctrl_nxt.force_key_expansion = 1'b0;
    end
  end

  assign kexp_busy_nxt = kexp_go ? 1'b1 : (kexp_clear ? 1'b0 : kexp_busy_r);

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------
  wire [CEC_IRQ_W-1:0] irq_events = {end_halt, end_final};
  wire [CEC_IRQ_W-1:0] irq_w1c    = wr_irq_stat ? i_reg_wdata[CEC_IRQ_W-1:0]
                                                : CEC_IRQ_RESET;

  // set wins over a write-one clear in the same cycle
  assign irq_stat_nxt = (irq_stat_r & ~irq_w1c) | irq_events;
  assign irq_mask_nxt = wr_irq_mask ? i_reg_wdata[CEC_IRQ_W-1:0] : irq_mask_r;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [31:0] status_word = {29'h0, ctrl_r.force_key_expansion, is_wait, is_idle};
  wire [31:0] irq_stat_w  = {30'h0, irq_stat_r};
  wire [31:0] irq_mask_w  = {30'h0, irq_mask_r};

  assign rdata_nxt = !i_reg_rd    ? 32'h0000_0000 :
                     hit_ctrl     ? 32'(ctrl_r)   :
                     hit_status   ? status_word   :
                     hit_irq_stat ? irq_stat_w    :
                     hit_irq_mask ? irq_mask_w    :
                     32'h0000_0000;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= CEC_S_IDLE;
      ctrl_r  <= cec_ctrl_t'(CEC_CTRL_RESET);
    end else begin
      state_r <= state_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_r <= CEC_IRQ_RESET;
      irq_mask_r <= CEC_IRQ_RESET;
      rdata_r    <= 32'h0000_0000;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      start_r     <= 1'b0;
      kexp_r      <= 1'b0;
      kexp_busy_r <= 1'b0;
      cfg_r       <= '0;
    end else begin
      start_r     <= start_ok;
      kexp_r      <= kexp_go;
      kexp_busy_r <= kexp_busy_nxt;
      cfg_r       <= cfg_dec;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign o_reg_rdata        = rdata_r;
  assign o_eng_start        = start_r;
  assign o_eng_kexp         = kexp_r;
  assign o_eng_cfg          = cfg_r;
  assign o_engine_idle_flag = is_idle;
  assign o_wait_for_input   = is_wait;
  assign o_irq              = ctrl_r.irq_enable && |(irq_stat_r & irq_mask_r);

endmodule

// file: pkg/cec_pkg.sv
package cec_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [31:0] CEC_ADDR_CTRL     = 32'h4002_0000;
  localparam logic [31:0] CEC_ADDR_START    = 32'h4002_0004;
  localparam logic [31:0] CEC_ADDR_STATUS   = 32'h4002_0014;
  localparam logic [31:0] CEC_ADDR_IRQ_STAT = 32'h4002_0030;
  localparam logic [31:0] CEC_ADDR_IRQ_MASK = 32'h4002_0034;

  localparam logic [31:0] CEC_CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CEC_CTRL_WMASK    = 32'h0003_FFFF;
  localparam int          CEC_START_BIT     = 0;

  // ---------------------------------------------------------------
  // status and interrupt bit positions
  // ---------------------------------------------------------------
  localparam int CEC_ST_IDLE_BIT = 0;
  localparam int CEC_ST_WAIT_BIT = 1;
  localparam int CEC_ST_KEXP_BIT = 2;
  localparam int CEC_IRQ_W       = 2;
  localparam int CEC_IRQ_DONE    = 0;
  localparam int CEC_IRQ_WAIT    = 1;
  localparam logic [CEC_IRQ_W-1:0] CEC_IRQ_RESET = 2'h0;

  // ---------------------------------------------------------------
  // field encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CEC_KSZ_128 = 2'h0;
  localparam logic [1:0] CEC_KSZ_192 = 2'h1;
  localparam logic [1:0] CEC_CHN_CTR = 2'h2;
  localparam logic [1:0] CEC_CHN_CBC = 2'h3;
  localparam logic [1:0] CEC_FAM_32  = 2'h0;
  localparam logic [1:0] CEC_FAM_64  = 2'h1;

  // digest sizes in bytes, per family and algorithm code
  localparam logic [6:0] CEC_DG_F32_0 = 7'h10;
  localparam logic [6:0] CEC_DG_F32_1 = 7'h14;
  localparam logic [6:0] CEC_DG_F32_2 = 7'h1C;
  localparam logic [6:0] CEC_DG_F32_3 = 7'h20;
  localparam logic [6:0] CEC_DG_F64_0 = 7'h30;
  localparam logic [6:0] CEC_DG_F64_1 = 7'h40;
  localparam logic [6:0] CEC_DG_F64_2 = 7'h1C;
  localparam logic [6:0] CEC_DG_F64_3 = 7'h20;
  localparam logic [6:0] CEC_DG_NONE  = 7'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [13:0] rsvd;
    logic        force_key_expansion;
    logic        more_input;
    logic [5:0]  digest_output_length;
    logic        hash_select;
    logic        irq_enable;
    logic        cipher_direction;
    logic [1:0]  cipher_key_size;
    logic        writeback_policy;
    logic [1:0]  algorithm_family_select;
    logic [1:0]  algorithm_select;
  } cec_ctrl_t;

  typedef enum logic [1:0] {
    CEC_KEY_128 = 2'h0,
    CEC_KEY_192 = 2'h1,
    CEC_KEY_256 = 2'h2
  } cec_key_t;

  typedef enum logic [1:0] {
    CEC_ECB = 2'h0,
    CEC_CTR = 2'h1,
    CEC_CBC = 2'h2
  } cec_chain_t;

  typedef struct packed {
    logic       is_hash;
    logic       encrypt;
    cec_key_t   key_size;
    cec_chain_t chain;
    logic       wide_family;
    logic [1:0] hash_alg;
    logic [6:0] digest_bytes;
    logic       length_ok;
    logic       final_block_only;
    logic       more_input;
  } cec_cfg_t;

  typedef enum logic [2:0] {
    CEC_S_IDLE = 3'b001,
    CEC_S_RUN  = 3'b010,
    CEC_S_WAIT = 3'b100
  } cec_state_t;

endpackage

// file: design/cec_cfg_decode.sv
`timescale 1ns/1ps
module cec_cfg_decode
  import cec_pkg::*;
(
  // raw control fields
  input  wire cec_ctrl_t i_ctrl,
  // decoded configuration
  output cec_cfg_t       o_cfg
);

  // ---------------------------------------------------------------
  // digest size lookup
  // ---------------------------------------------------------------
  function automatic logic [6:0] cec_digest_max(input logic [1:0] fam,
                                                 input logic [1:0] alg);
    logic [6:0] sz;
    sz = CEC_DG_NONE;
    if (fam == CEC_FAM_32) begin
      unique case (alg)
        2'h0: sz = CEC_DG_F32_0;
        2'h1: sz = CEC_DG_F32_1;
        2'h2: sz = CEC_DG_F32_2;
        2'h3: sz = CEC_DG_F32_3;
      endcase
    end else if (fam == CEC_FAM_64) begin
      unique case (alg)
        2'h0: sz = CEC_DG_F64_0;
        2'h1: sz = CEC_DG_F64_1;
        2'h2: sz = CEC_DG_F64_2;
        2'h3: sz = CEC_DG_F64_3;
      endcase
    end
    return sz;
  endfunction

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire [6:0]  max_bytes = cec_digest_max(i_ctrl.algorithm_family_select,
                                         i_ctrl.algorithm_select);
  wire [6:0]  req_bytes = {1'b0, i_ctrl.digest_output_length} + 7'h01;
  wire        len_ok    = (max_bytes != CEC_DG_NONE) && (req_bytes <= max_bytes);
  wire        is_hash   = i_ctrl.hash_select;
  cec_key_t   key_sz;
  cec_chain_t chain;

  assign key_sz = (i_ctrl.cipher_key_size == CEC_KSZ_128) ? CEC_KEY_128 :
                  (i_ctrl.cipher_key_size == CEC_KSZ_192) ? CEC_KEY_192 :
                  CEC_KEY_256;
  assign chain  = (i_ctrl.algorithm_family_select == CEC_CHN_CTR) ? CEC_CTR :
                  (i_ctrl.algorithm_family_select == CEC_CHN_CBC) ? CEC_CBC :
                  CEC_ECB;

  assign o_cfg.is_hash          = is_hash;
  assign o_cfg.encrypt          = i_ctrl.cipher_direction;
  assign o_cfg.key_size         = key_sz;
  assign o_cfg.chain            = chain;
  assign o_cfg.wide_family      = is_hash &&
                                  (i_ctrl.algorithm_family_select == CEC_FAM_64);
  assign o_cfg.hash_alg         = i_ctrl.algorithm_select;
  assign o_cfg.digest_bytes     = len_ok ? req_bytes : max_bytes;
  assign o_cfg.length_ok        = len_ok;
  assign o_cfg.final_block_only = !is_hash && i_ctrl.writeback_policy;
  assign o_cfg.more_input       = i_ctrl.more_input;

endmodule

// file: tb/cec_checker.sv
`timescale 1ns/1ps
module cec_checker
  import cec_pkg::*;
(
  // clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_resetn,
  // register port
  input wire logic [31:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // engine side
  input wire logic        i_eng_input_done,
  input wire logic        i_eng_kexp_done,
  input wire logic        o_eng_start,
  input wire logic        o_eng_kexp,
  input wire cec_cfg_t    o_eng_cfg,
  input wire logic        o_engine_idle_flag,
  input wire logic        o_wait_for_input,
  input wire logic        o_irq
);
  // ---------------------------------------------------------------
  // shadow of the control word, and a copy aligned with the config
  // ---------------------------------------------------------------
  logic [31:0] sh_r;
  logic [31:0] e_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_r <= 32'h0;
      e_r  <= 32'h0;
    end else begin
      if (i_reg_wr && i_reg_addr == CEC_ADDR_CTRL) begin
        sh_r <= i_reg_wdata & CEC_CTRL_WMASK;
      end
      e_r <= sh_r;
    end
  end
  wire logic       run_w   = !o_engine_idle_flag && !o_wait_for_input;
  wire cec_key_t   key_w   = (e_r[6:5] == CEC_KSZ_128) ? CEC_KEY_128 :
                             (e_r[6:5] == CEC_KSZ_192) ? CEC_KEY_192 : CEC_KEY_256;
  wire cec_chain_t chain_w = (e_r[3:2] == CEC_CHN_CTR) ? CEC_CTR :
                             (e_r[3:2] == CEC_CHN_CBC) ? CEC_CBC : CEC_ECB;
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_final_done;
    run_w && i_eng_input_done && !sh_r[16];
  endsequence
  sequence s_part_done;
    run_w && i_eng_input_done && sh_r[16];
  endsequence
  a_start_one_cycle: assert property (o_eng_start |=> !o_eng_start)
    else $error("start pulse longer than one cycle");
  a_start_runs: assert property (o_eng_start |-> run_w)
    else $error("start without running state");
  a_kexp_with_start: assert property (o_eng_kexp |-> o_eng_start)
    else $error("key expansion outside start");
  a_final_to_idle: assert property (s_final_done |=> o_engine_idle_flag && !o_wait_for_input)
    else $error("last input did not end in idle");
  a_more_to_wait: assert property (s_part_done |=> o_wait_for_input && !o_engine_idle_flag)
    else $error("partial input did not halt in wait");
  a_irq_needs_enable: assert property (o_irq |-> sh_r[8])
    else $error("interrupt while disabled");
  a_type_select: assert property (o_eng_cfg.is_hash == e_r[9])
    else $error("type bit not decoded");
  a_dir_bit: assert property (!e_r[9] |-> o_eng_cfg.encrypt == e_r[7])
    else $error("direction decode wrong");
  a_key_size_map: assert property (!e_r[9] |-> o_eng_cfg.key_size == key_w)
    else $error("key size decode wrong");
  a_chain_map: assert property (!e_r[9] |-> o_eng_cfg.chain == chain_w)
    else $error("chaining decode wrong");
  a_writeback_map: assert property (!e_r[9] |-> o_eng_cfg.final_block_only == e_r[4])
    else $error("writeback decode wrong");
  a_hash_family: assert property (e_r[9] && !e_r[3] |->
    o_eng_cfg.wide_family == e_r[2] && o_eng_cfg.hash_alg == e_r[1:0])
    else $error("hash family decode wrong");
  a_digest_len: assert property (e_r[9] && e_r[3:2] == 2'h0 && e_r[15:10] < 6'h10 |->
    o_eng_cfg.digest_bytes == {1'b0, e_r[15:10]} + 7'h01)
    else $error("digest length decode wrong");
  a_more_input_copy: assert property (o_eng_cfg.more_input == e_r[16])
    else $error("more input bit not carried");
  a_reserved_family: assert property (e_r[9] && e_r[3] |->
    !o_eng_cfg.length_ok && o_eng_cfg.digest_bytes == 7'h00)
    else $error("reserved hash family not flagged");
endmodule

bind cec_top cec_checker cec_checker_inst (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_eng_input_done(i_eng_input_done),
  .i_eng_kexp_done(i_eng_kexp_done), .o_eng_start(o_eng_start), .o_eng_kexp(o_eng_kexp),
  .o_eng_cfg(o_eng_cfg), .o_engine_idle_flag(o_engine_idle_flag),
  .o_wait_for_input(o_wait_for_input), .o_irq(o_irq)
);

// file: tb/cec_top_tb.sv
`timescale 1ns/1ps
module cec_top_tb
  import cec_pkg::*;
;
  logic        i_sys_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        done = 1'b0;
  logic        kdone = 1'b0;
  logic [31:0] rdata;
  logic        start;
  logic        kexp;
  cec_cfg_t    cfg;
  logic        idle;
  logic        waitf;
  logic        irq;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  cec_top cec_top_inst (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_eng_input_done(done),
    .i_eng_kexp_done(kdone), .o_eng_start(start), .o_eng_kexp(kexp), .o_eng_cfg(cfg),
    .o_engine_idle_flag(idle), .o_wait_for_input(waitf), .o_irq(irq)
  );

  always #5 i_sys_clk = ~i_sys_clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    if (fails == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [31:0] a, input logic [31:0] exp);
    @(posedge i_sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_sys_clk);
    rd <= 1'b0;
    #1;
    chk32(rdata, exp);
  endtask
  task automatic eng(input logic k);
    @(posedge i_sys_clk);
    kdone <= k;
    done <= !k;
    @(posedge i_sys_clk);
    kdone <= 1'b0;
    done <= 1'b0;
    #1;
  endtask

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_sim();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    #1;
    chk1(idle, 1'b1);
    chk1(irq, 1'b0);
    rd_reg(CEC_ADDR_CTRL, CEC_CTRL_RESET);
    rd_reg(CEC_ADDR_STATUS, 32'h1);
    rd_reg(32'h4002_0008, 32'h0);
    rd_reg(CEC_ADDR_IRQ_MASK, 32'h0);
    wr_reg(CEC_ADDR_CTRL, 32'hFFFF_FFFF);
    rd_reg(CEC_ADDR_CTRL, CEC_CTRL_WMASK);
    rd_reg(CEC_ADDR_START, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wr_reg(CEC_ADDR_CTRL, (32'(i) << 5) | (32'(i) << 2) | (32'(i & 1) << 7));
      @(posedge i_sys_clk);
      #1;
      chk32(32'(cfg.key_size), (i == 0) ? 32'h0 : (i == 1) ? 32'h1 : 32'h2);
      chk1(cfg.encrypt, 1'(i & 1));
      chk32(32'(cfg.chain), (i == 2) ? 32'(CEC_CTR) : (i == 3) ? 32'(CEC_CBC) : 32'(CEC_ECB));
    end
    for (int j = 0; j < 8; j++) begin
      wr_reg(CEC_ADDR_CTRL, 32'h0000_3E00 | (32'(j >> 2) << 2) | 32'(j & 3));
      @(posedge i_sys_clk);
      #1;
      chk32(32'(cfg.digest_bytes), 32'h10);
      chk1(cfg.length_ok, 1'b1);
    end
    wr_reg(CEC_ADDR_CTRL, 32'h0000_5201);
    @(posedge i_sys_clk);
    #1;
    chk32(32'(cfg.digest_bytes), 32'h14);
    chk1(cfg.length_ok, 1'b0);
    // reserved hash family
    wr_reg(CEC_ADDR_CTRL, 32'h0000_0208);
    @(posedge i_sys_clk);
    #1;
    chk32(32'(cfg.digest_bytes), 32'h0);
    chk1(cfg.length_ok, 1'b0);
    // cipher run with forced expansion, last input, interrupt masked then unmasked
    wr_reg(CEC_ADDR_IRQ_MASK, 32'h2);
    wr_reg(CEC_ADDR_CTRL, 32'h0002_01DC);
    wr_reg(CEC_ADDR_START, 32'h1);
    chk1(start, 1'b1);
    chk1(kexp, 1'b1);
    chk1(idle, 1'b0);
    rd_reg(CEC_ADDR_STATUS, 32'h4);
    eng(1'b1);
    rd_reg(CEC_ADDR_CTRL, 32'h0000_01DC);
    eng(1'b0);
    chk1(idle, 1'b1);
    chk1(irq, 1'b0);
    rd_reg(CEC_ADDR_IRQ_STAT, 32'h1);
    wr_reg(CEC_ADDR_IRQ_MASK, 32'h3);
    chk1(irq, 1'b1);
    wr_reg(CEC_ADDR_IRQ_STAT, 32'h1);
    rd_reg(CEC_ADDR_IRQ_STAT, 32'h0);
    chk1(irq, 1'b0);
    eng(1'b0);
    rd_reg(CEC_ADDR_IRQ_STAT, 32'h0);
    // more input follows, interrupt disabled
    wr_reg(CEC_ADDR_CTRL, 32'h0001_0000);
    wr_reg(CEC_ADDR_START, 32'h1);
    chk1(start, 1'b1);
    chk1(kexp, 1'b0);
    wr_reg(CEC_ADDR_START, 32'h1);
    chk1(start, 1'b0);
    eng(1'b0);
    chk1(waitf, 1'b1);
    chk1(idle, 1'b0);
    chk1(irq, 1'b0);
    rd_reg(CEC_ADDR_IRQ_STAT, 32'h2);
    wr_reg(CEC_ADDR_START, 32'h1);
    chk1(start, 1'b1);
    chk1(waitf, 1'b0);
    eng(1'b0);
    chk1(waitf, 1'b1);
    // reset while halted
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    #1;
    chk1(idle, 1'b1);
    rd_reg(CEC_ADDR_CTRL, CEC_CTRL_RESET);
    end_sim();
  end
endmodule
